// ===== verilog/lsmu_map.svh
// Offsets, field positions, encodings and reset values of the load/store multiple unit.
`ifndef LSMU_MAP_SVH
`define LSMU_MAP_SVH
`define LSMU_CTRL_OFF 8'h00
`define LSMU_STATUS_OFF 8'h04
`define LSMU_COUNT_OFF 8'h08
`define LSMU_CYCLES_OFF 8'h0c
`define LSMU_CTRL_EN_RST 1'b1
`define LSMU_CYC_IDLE 2'h0
`define LSMU_CYC_N 2'h1
`define LSMU_CYC_S 2'h2
`define LSMU_CYC_I 2'h3
`define LSMU_PC_IDX 4'hf
`define LSMU_PC_BASE_ADJ 32'h8
`define LSMU_PC_STORE_ADJ 32'hc
`define LSMU_WORD_STEP 32'h4
`define LSMU_F_IMMOFF 25
`define LSMU_F_PRE 24
`define LSMU_F_UP 23
`define LSMU_F_BYTE 22
`define LSMU_F_WB 21
`define LSMU_F_LOAD 20
`define LSMU_F_PC_IN_LIST 15
`endif

// ===== verilog/lsmu_pkg.sv
// Types shared by the load/store multiple unit.
package lsmu_pkg;
   typedef logic [1:0] lsmu_cyc_t;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_SA = 9'h002,
      ST_SB = 9'h004,
      ST_FIN = 9'h008,
      ST_RF_N = 9'h010,
      ST_RF_S = 9'h020,
      ST_BP = 9'h040,
      ST_BX = 9'h080,
      ST_BI = 9'h100
   } lsmu_state_e;
   typedef struct packed {
      lsmu_state_e st;
      logic [31:0] instr;
      logic [31:0] pc;
      logic [31:0] xaddr;
      logic [31:0] nbase;
      logic [15:0] mask;
      logic [3:0] cur;
      logic first;
      logic user;
      logic issue_ready;
      logic wr_en;
      logic [3:0] wr_idx;
      logic [31:0] wr_data;
      logic wb_en;
      logic [3:0] wb_idx;
      logic [31:0] wb_data;
      logic psr_restore;
      lsmu_cyc_t cyc;
      logic xfer;
      logic mem_wr;
      logic mem_byte;
      logic unpriv;
      logic [31:0] mem_addr;
      logic [31:0] wdata;
      logic [3:0] src;
      logic done;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic ctrl_en;
      logic unsup;
      logic [15:0] retired;
      logic [7:0] cnt_n;
      logic [7:0] cnt_s;
      logic [7:0] cnt_i;
      logic [7:0] last_n;
      logic [7:0] last_s;
      logic [7:0] last_i;
   } lsmu_regs_s;
endpackage

// ===== verilog/lsmu_core.sv
// Execution unit for single and block load/store instructions with an APB status port.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "lsmu_map.svh"
module lsmu_core (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic issue_valid,
   input wire logic [31:0] issue_instr,
   input wire logic [31:0] issue_pc,
   input wire logic [31:0] base_val,
   input wire logic [31:0] index_val,
   output logic issue_ready,
   output logic [3:0] rf_rd_idx,
   input wire logic [31:0] rf_rd_data,
   output logic rf_user_bank,
   output logic rf_wr_en,
   output logic [3:0] rf_wr_idx,
   output logic [31:0] rf_wr_data,
   output logic wb_en,
   output logic [3:0] wb_idx,
   output logic [31:0] wb_data,
   output logic psr_restore,
   output lsmu_pkg::lsmu_cyc_t mem_cyc,
   output logic mem_xfer,
   output logic mem_wr,
   output logic mem_byte,
   output logic mem_unpriv,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   output logic instr_done
);
   import lsmu_pkg::*;

   lsmu_regs_s r;
   lsmu_regs_s n;

   function automatic logic [3:0] lowest_set(input logic [15:0] m);
      lowest_set = 4'h0;
      for (int k = 15; k >= 0; k--) begin
         if (m[k]) begin
            lowest_set = 4'(k);
         end
      end
   endfunction

   function automatic logic [4:0] count_set(input logic [15:0] m);
      count_set = 5'h0;
      for (int k = 0; k < 16; k++) begin
         count_set = count_set + 5'(m[k]);
      end
   endfunction

   // A rotate by zero passes the value through, as there is no carry input here.
   function automatic logic [31:0] shift_imm(input logic [31:0] v, input logic [4:0] amt,
                                             input logic [1:0] typ);
      logic [63:0] rot;
      rot = {v, v} >> amt;
      case (typ)
         2'h0: shift_imm = v << amt;
         2'h1: shift_imm = (amt == 5'h0) ? 32'h0 : v >> amt;
         2'h2: shift_imm = (amt == 5'h0) ? {32{v[31]}} : 32'($signed(v) >>> amt);
         default: shift_imm = rot[31:0];
      endcase
   endfunction

   logic [31:0] di;
   logic acc;
   logic is_sgl;
   logic is_blk;
   logic [3:0] rn_idx;
   logic post_w;
   logic [31:0] imm12;
   logic [31:0] base_eff;
   logic [31:0] offset;
   logic [31:0] moved;
   logic [31:0] nbytes;
   logic [31:0] blk_start;
   logic [31:0] blk_end;
   logic [31:0] src_val;
   logic [31:0] bsh;
   logic [31:0] ld_val;
   logic [15:0] rem;
   logic r_load;
   logic r_wb_req;

   always_comb begin
      di = issue_instr;
      acc = issue_valid && r.issue_ready;
      is_sgl = (di[27:26] == 2'h1);
      is_blk = (di[27:25] == 3'h4);
      rn_idx = di[19:16];
      post_w = !di[`LSMU_F_PRE] && di[`LSMU_F_WB];
      imm12 = {20'h0, di[11:0]};
      base_eff = (rn_idx == `LSMU_PC_IDX) ? issue_pc + `LSMU_PC_BASE_ADJ : base_val;
      offset = di[`LSMU_F_IMMOFF] ? shift_imm(index_val, di[11:7], di[6:5]) : imm12;
      moved = di[`LSMU_F_UP] ? base_eff + offset : base_eff - offset;
      nbytes = {25'h0, count_set(di[15:0]), 2'h0};
      case ({di[`LSMU_F_PRE], di[`LSMU_F_UP]})
         2'h1: blk_start = base_val;
         2'h3: blk_start = base_val + `LSMU_WORD_STEP;
         2'h0: blk_start = base_val - nbytes + `LSMU_WORD_STEP;
         default: blk_start = base_val - nbytes;
      endcase
      blk_end = di[`LSMU_F_UP] ? base_val + nbytes : base_val - nbytes;
      // The base written back this cycle is not yet in the register file, so forward it.
      if (r.cur == `LSMU_PC_IDX) begin
         src_val = r.pc + `LSMU_PC_STORE_ADJ;
      end else if (r.wb_en && r.cur == r.wb_idx) begin
         src_val = r.wb_data;
      end else begin
         src_val = rf_rd_data;
      end
      bsh = mem_rdata >> {r.xaddr[1:0], 3'h0};
      ld_val = r.instr[`LSMU_F_BYTE] ? {24'h0, bsh[7:0]} : mem_rdata;
      rem = r.mask & ~(16'h1 << r.cur);
      r_load = r.instr[`LSMU_F_LOAD];
      r_wb_req = !r.instr[`LSMU_F_PRE] || r.instr[`LSMU_F_WB];
   end

   always_comb begin
      n = r;
      n.wr_en = 1'b0;
      n.wb_en = 1'b0;
      n.psr_restore = 1'b0;
      n.done = 1'b0;
      n.xfer = 1'b0;
      n.mem_wr = 1'b0;
      n.unpriv = 1'b0;
      n.cyc = `LSMU_CYC_IDLE;
      n.pready = psel && !penable;
      n.pslverr = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            `LSMU_CTRL_OFF: n.prdata = {31'h0, r.ctrl_en};
            `LSMU_STATUS_OFF: n.prdata = {30'h0, r.unsup, r.st != ST_IDLE};
            `LSMU_COUNT_OFF: n.prdata = {16'h0, r.retired};
            `LSMU_CYCLES_OFF: n.prdata = {8'h0, r.last_i, r.last_s, r.last_n};
            default: begin
               n.prdata = 32'h0;
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && r.pready && pwrite) begin
         if (paddr == `LSMU_CTRL_OFF) begin
            n.ctrl_en = pwdata[0];
         end
         if (paddr == `LSMU_STATUS_OFF && pwdata[1]) begin
            n.unsup = 1'b0;
         end
      end
      if (r.cyc != `LSMU_CYC_IDLE) begin
         n.cnt_n = r.cnt_n + 8'(r.cyc == `LSMU_CYC_N);
         n.cnt_s = r.cnt_s + 8'(r.cyc == `LSMU_CYC_S);
         n.cnt_i = r.cnt_i + 8'(r.cyc == `LSMU_CYC_I);
         if (r.done) begin
            n.last_n = n.cnt_n;
            n.last_s = n.cnt_s;
            n.last_i = n.cnt_i;
            n.cnt_n = 8'h0;
            n.cnt_s = 8'h0;
            n.cnt_i = 8'h0;
            n.retired = r.retired + 16'h1;
         end
      end
      case (r.st)
         ST_IDLE: begin
            if (acc && is_sgl) begin
               n.instr = di;
               n.pc = issue_pc;
               n.xaddr = di[`LSMU_F_PRE] ? moved : base_eff;
               n.nbase = moved;
               n.cur = di[15:12];
               n.user = 1'b0;
               n.st = ST_SA;
               n.cyc = `LSMU_CYC_N;
               if (di[`LSMU_F_LOAD]) begin
                  n.xfer = 1'b1;
                  n.mem_addr = n.xaddr;
                  n.mem_byte = di[`LSMU_F_BYTE];
                  n.unpriv = post_w;
               end
            end else if (acc && is_blk) begin
               n.instr = di;
               n.pc = issue_pc;
               n.mask = di[15:0];
               n.cur = lowest_set(di[15:0]);
               n.user = di[`LSMU_F_BYTE] && !(di[`LSMU_F_LOAD] && di[15]);
               n.nbase = blk_end;
               n.first = 1'b1;
               n.cyc = `LSMU_CYC_N;
               n.mem_addr = blk_start;
               n.mem_byte = 1'b0;
               n.xfer = di[`LSMU_F_LOAD];
               n.st = di[`LSMU_F_LOAD] ? ST_BX : ST_BP;
            end else if (acc) begin
               n.unsup = 1'b1;
            end
         end
         ST_SA: begin
            n.wb_en = r_wb_req && r.instr[19:16] != `LSMU_PC_IDX &&
                      !(r_load && r.instr[15:12] == r.instr[19:16]);
            n.wb_idx = r.instr[19:16];
            n.wb_data = r.nbase;
            n.st = ST_SB;
            if (r_load) begin
               n.wr_en = 1'b1;
               n.wr_idx = r.cur;
               n.wr_data = ld_val;
               n.cyc = `LSMU_CYC_I;
            end else begin
               n.xfer = 1'b1;
               n.mem_wr = 1'b1;
               n.mem_addr = r.xaddr;
               n.mem_byte = r.instr[`LSMU_F_BYTE];
               n.unpriv = !r.instr[`LSMU_F_PRE] && r.instr[`LSMU_F_WB];
               n.wdata = r.instr[`LSMU_F_BYTE] ? {4{src_val[7:0]}} : src_val;
               n.src = r.cur;
               n.cyc = `LSMU_CYC_N;
               n.done = 1'b1;
            end
         end
         ST_SB: begin
            if (r_load && r.cur == `LSMU_PC_IDX) begin
               n.st = ST_RF_N;
               n.cyc = `LSMU_CYC_N;
            end else if (r_load) begin
               n.st = ST_FIN;
               n.cyc = `LSMU_CYC_S;
               n.done = 1'b1;
            end else begin
               n.st = ST_IDLE;
            end
         end
         ST_RF_N: begin
            n.st = ST_RF_S;
            n.cyc = `LSMU_CYC_S;
         end
         ST_RF_S: begin
            n.st = ST_FIN;
            n.cyc = `LSMU_CYC_S;
            n.done = 1'b1;
         end
         ST_FIN: begin
            n.st = ST_IDLE;
         end
         ST_BP: begin
            n.xfer = 1'b1;
            n.mem_wr = 1'b1;
            n.wdata = src_val;
            n.src = r.cur;
            n.mask = rem;
            n.cur = lowest_set(rem);
            n.wb_en = r.instr[`LSMU_F_WB];
            n.wb_idx = r.instr[19:16];
            n.wb_data = r.nbase;
            n.cyc = `LSMU_CYC_N;
            n.st = ST_BX;
            n.done = (rem == 16'h0);
         end
         ST_BX: begin
            if (r_load) begin
               n.wr_en = 1'b1;
               n.wr_idx = r.cur;
               n.wr_data = mem_rdata;
               n.psr_restore = r.cur == `LSMU_PC_IDX && r.instr[`LSMU_F_BYTE];
               // A loaded base wins over the written-back one.
               n.wb_en = r.first && r.instr[`LSMU_F_WB] && r.cur != r.instr[19:16];
               n.wb_idx = r.instr[19:16];
               n.wb_data = r.nbase;
               n.first = 1'b0;
               n.mask = rem;
               if (rem != 16'h0) begin
                  n.xfer = 1'b1;
                  n.mem_addr = r.mem_addr + `LSMU_WORD_STEP;
                  n.cur = lowest_set(rem);
                  n.cyc = `LSMU_CYC_S;
               end else begin
                  n.st = ST_BI;
                  n.cyc = `LSMU_CYC_I;
               end
            end else if (r.mask != 16'h0) begin
               n.xfer = 1'b1;
               n.mem_wr = 1'b1;
               n.mem_addr = r.mem_addr + `LSMU_WORD_STEP;
               n.wdata = src_val;
               n.src = r.cur;
               n.mask = rem;
               n.cur = lowest_set(rem);
               n.cyc = `LSMU_CYC_S;
               n.done = (rem == 16'h0);
            end else begin
               n.st = ST_IDLE;
            end
         end
         ST_BI: begin
            n.st = r.instr[`LSMU_F_PC_IN_LIST] ? ST_RF_N : ST_FIN;
            n.cyc = r.instr[`LSMU_F_PC_IN_LIST] ? `LSMU_CYC_N : `LSMU_CYC_S;
            n.done = !r.instr[`LSMU_F_PC_IN_LIST];
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      n.issue_ready = (n.st == ST_IDLE) && n.ctrl_en;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.ctrl_en <= `LSMU_CTRL_EN_RST;
         r.issue_ready <= `LSMU_CTRL_EN_RST;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign issue_ready = r.issue_ready;
   assign rf_rd_idx = r.cur;
   assign rf_user_bank = r.user;
   assign rf_wr_en = r.wr_en;
   assign rf_wr_idx = r.wr_idx;
   assign rf_wr_data = r.wr_data;
   assign wb_en = r.wb_en;
   assign wb_idx = r.wb_idx;
   assign wb_data = r.wb_data;
   assign psr_restore = r.psr_restore;
   assign mem_cyc = r.cyc;
   assign mem_xfer = r.xfer;
   assign mem_wr = r.mem_wr;
   assign mem_byte = r.mem_byte;
   assign mem_unpriv = r.unpriv;
   assign mem_addr = r.mem_addr;
   assign mem_wdata = r.wdata;
   assign instr_done = r.done;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   a_ldr_cycle_seq: assert property (acc && is_sgl && di[20] && di[15:12] != 4'hf |=>
      r.cyc == 2'h1 ##1 r.cyc == 2'h3 ##1 (r.cyc == 2'h2 && r.done))
      else $error("single load cycle sequence wrong");
   a_ldr_pc_seq: assert property (acc && is_sgl && di[20] && di[15:12] == 4'hf |=>
      r.cyc == 2'h1 ##1 r.cyc == 2'h3 ##1 r.cyc == 2'h1 ##1 r.cyc == 2'h2 ##1
      (r.cyc == 2'h2 && r.done))
      else $error("program counter load cycle sequence wrong");
   a_str_two_n: assert property (acc && is_sgl && !di[20] |=>
      (r.cyc == 2'h1 && !r.xfer) ##1 (r.cyc == 2'h1 && r.xfer && r.mem_wr && r.done) ##1
      r.cyc == 2'h0)
      else $error("single store cycles wrong");
   a_unpriv_post: assert property (acc && is_sgl && di[20] |=> r.unpriv == $past(post_w))
      else $error("unprivileged flag wrong");
   a_byte_zero_fill: assert property (acc && is_sgl && di[20] && di[22] |=>
      ##1 (r.wr_en && r.wr_data[31:8] == 24'h0))
      else $error("byte load not zero extended");
   a_pc_base_adj: assert property (acc && is_sgl && di[20] && rn_idx == 4'hf && !di[25] &&
      di[24] && di[23] |=> r.mem_addr == $past(issue_pc) + 32'h8 + $past(imm12) ##1 !r.wb_en)
      else $error("program counter base wrong");
   a_stm_pc_value: assert property (r.xfer && r.mem_wr && r.src == 4'hf &&
      r.instr[27:25] == 3'h4 |-> r.wdata == r.pc + 32'hc)
      else $error("stored program counter wrong");
   a_addr_ascend: assert property (r.xfer && r.cyc == 2'h2 |->
      r.mem_addr == $past(r.mem_addr) + 32'h4)
      else $error("block addresses not ascending");
   a_no_wb_clear: assert property (r.st != ST_IDLE && r.instr[27:25] == 3'h4 &&
      !r.instr[21] |-> !r.wb_en)
      else $error("write-back without request");
   a_psr_with_pc: assert property (r.psr_restore |-> r.wr_en && r.wr_idx == 4'hf)
      else $error("status restore without program counter");
   a_user_bank_sel: assert property (r.xfer && r.instr[27:25] == 3'h4 && r.instr[22] &&
      !(r.instr[20] && r.instr[15]) |-> r.user)
      else $error("user bank not selected");
   a_wb_second_cyc: assert property (acc && is_blk && !di[20] && di[21] |=>
      ##1 (r.wb_en && r.wb_idx == $past(rn_idx, 2) && r.mem_wr))
      else $error("block write-back not in second cycle");

   c_block_load: cover property (acc && is_blk && di[20]);
   c_block_store: cover property (acc && is_blk && !di[20] && di[21]);
   c_status_restore: cover property (r.psr_restore);
   c_single_byte: cover property (acc && is_sgl && di[22]);
endmodule

// ===== sim/lsmu_mem_model.sv
// Zero-wait memory model standing behind the unit's address and data bus.
`timescale 1ns/10ps
module lsmu_mem_model (
   input wire logic clock,
   input wire logic mem_xfer,
   input wire logic mem_wr,
   input wire logic mem_byte,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [0:255];
   logic [31:0] last_r;
   initial last_r = 32'h0;
   // A bus that is not read shows the inverse of its last word, so stale data cannot pass.
   assign mem_rdata = (mem_xfer && !mem_wr) ? mem[mem_addr[9:2]] : ~last_r;
   always @(posedge clock) begin
      last_r <= mem_rdata;
      if (mem_xfer && mem_wr) begin
         if (mem_byte) begin
            mem[mem_addr[9:2]][8*mem_addr[1:0] +: 8] <= mem_wdata[8*mem_addr[1:0] +: 8];
         end else begin
            mem[mem_addr[9:2]] <= mem_wdata;
         end
      end
   end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the load/store multiple unit.
`timescale 1ns/10ps
`include "lsmu_map.svh"
module testbench;
   logic clock, rstn, psel, penable, pwrite, pready, pslverr, issue_valid, issue_ready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, issue_instr, issue_pc, base_val, rf_rd_data;
   logic [31:0] rf_wr_data, wb_data, mem_addr, mem_wdata, mem_rdata, rd, index_val, seen_cyc;
   logic [3:0] rf_rd_idx, rf_wr_idx, wb_idx;
   logic [1:0] mem_cyc;
   logic rf_user_bank, rf_wr_en, wb_en, psr_restore, mem_xfer, mem_wr, mem_byte;
   logic mem_unpriv, instr_done, err, unp, ub;
   logic [31:0] regs [0:15];
   logic [31:0] uregs [0:15];
   logic [31:0] addrs [$];
   int bad_count, comparisons, psr_n, n_ins;
   lsmu_core u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .issue_valid(issue_valid), .issue_instr(issue_instr),
      .issue_pc(issue_pc), .base_val(base_val), .index_val(index_val),
      .issue_ready(issue_ready), .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data),
      .rf_user_bank(rf_user_bank), .rf_wr_en(rf_wr_en), .rf_wr_idx(rf_wr_idx),
      .rf_wr_data(rf_wr_data), .wb_en(wb_en), .wb_idx(wb_idx), .wb_data(wb_data),
      .psr_restore(psr_restore), .mem_cyc(mem_cyc), .mem_xfer(mem_xfer), .mem_wr(mem_wr),
      .mem_byte(mem_byte), .mem_unpriv(mem_unpriv), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .instr_done(instr_done));
   lsmu_mem_model u_mem (.clock(clock), .mem_xfer(mem_xfer), .mem_wr(mem_wr),
      .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));
   assign rf_rd_data = rf_user_bank ? uregs[rf_rd_idx] : regs[rf_rd_idx];
   always @(posedge clock) begin
      if (rf_wr_en) begin
         if (rf_user_bank) begin
            uregs[rf_wr_idx] <= rf_wr_data;
         end else begin
            regs[rf_wr_idx] <= rf_wr_data;
         end
      end
      if (wb_en) begin
         regs[wb_idx] <= wb_data;
      end
      if (mem_xfer) begin
         addrs.push_back(mem_addr);
      end
      psr_n <= psr_n + int'(psr_restore);
      unp <= unp | mem_unpriv;
      ub <= ub | rf_user_bank;
      case (mem_cyc)
         2'h1: seen_cyc[7:0] <= seen_cyc[7:0] + 8'h1;
         2'h2: seen_cyc[15:8] <= seen_cyc[15:8] + 8'h1;
         2'h3: seen_cyc[23:16] <= seen_cyc[23:16] + 8'h1;
         default: ;
      endcase
   end
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic end_of_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         bad_count++;
         end_of_test();
      end
   endtask
   // Encoders build only immediate-offset, legal streams; the f bits pick privilege and the other flags.
   function automatic logic [31:0] sdt(input logic [4:0] f, input logic [3:0] rn,
         input logic [3:0] rt, input logic [11:0] off);
      return {4'he, 3'b010, f, rn, rt, off};
   endfunction
   function automatic logic [31:0] blk(input logic [4:0] f, input logic [3:0] rn,
         input logic [15:0] list);
      return {4'he, 3'b100, f, rn, list};
   endfunction
   task automatic run(input logic [31:0] ins, input logic [31:0] pc, input logic [31:0] cyc);
      int i;
      // Clearing on the falling edge keeps the clear from racing the edge-driven accumulators.
      @(negedge clock);
      addrs.delete();
      psr_n = 0;
      unp = 1'b0;
      ub = 1'b0;
      seen_cyc = 32'h0;
      @(posedge clock);
      issue_valid <= 1'b1;
      issue_instr <= ins;
      issue_pc <= pc;
      base_val <= regs[ins[19:16]];
      index_val <= regs[ins[3:0]];
      @(posedge clock);
      issue_valid <= 1'b0;
      for (i = 0; i < 50; i++) begin
         @(negedge clock);
         if (instr_done === 1'b1) break;
      end
      if (i == 50) begin
         bad_count++;
         end_of_test();
      end
      n_ins++;
      apb(1'b0, `LSMU_CYCLES_OFF, 32'h0);
      chk(rd, cyc);
      chk(seen_cyc, cyc);
   endtask
   initial begin
      {psel, penable, pwrite, issue_valid, rstn} = 5'h0;
      {paddr, pwdata, issue_instr, issue_pc, base_val, index_val} = '0;
      for (int i = 0; i < 16; i++) begin
         regs[i] = 32'hc000 + 32'(i);
         uregs[i] = 32'hd000 + 32'(i);
      end
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      chk({28'h0, issue_ready, mem_xfer, instr_done, pready}, 32'h8);
      apb(1'b0, `LSMU_CTRL_OFF, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `LSMU_CTRL_OFF, 32'h0);
      @(negedge clock);
      chk({31'h0, issue_ready}, 32'h0);
      apb(1'b1, `LSMU_CTRL_OFF, 32'h1);
      regs[2] = 32'h100;
      u_mem.mem[8'h44] = 32'h11223344;
      run(sdt(5'h19, 4'h2, 4'h1, 12'h010), 32'h0, 32'h00010101);
      chk(regs[1], 32'h11223344);
      u_mem.mem[8'h41] = 32'haabbccdd;
      run(sdt(5'h1d, 4'h2, 4'h1, 12'h005), 32'h0, 32'h00010101);
      chk(regs[1], 32'h000000cc);
      u_mem.mem[8'h40] = 32'h200;
      run(sdt(5'h19, 4'h2, 4'hf, 12'h000), 32'h0, 32'h00010202);
      chk(regs[15], 32'h200);
      regs[3] = 32'h12345678;
      run(sdt(5'h0e, 4'h2, 4'h3, 12'h004), 32'h0, 32'h00000002);
      chk(u_mem.mem[8'h40], 32'h00000278);
      chk({31'h0, unp}, 32'h1);
      chk(regs[2], 32'h104);
      regs[6] = 32'h4;
      u_mem.mem[8'h45] = 32'h6b6b;
      run(sdt(5'h19, 4'h2, 4'h4, 12'h106) | 32'h02000000, 32'h0, 32'h00010101);
      chk(addrs[0], 32'h114);
      chk(regs[4], 32'h6b6b);
      u_mem.mem[8'h26] = 32'h5a5a;
      run(sdt(5'h19, 4'hf, 4'h4, 12'h010), 32'h80, 32'h00010101);
      chk(addrs[0], 32'h98);
      chk(regs[4], 32'h5a5a);
      regs[9] = 32'h201;
      run(blk(5'h0a, 4'h9, 16'h80a2), 32'h40, 32'h00000302);
      chk(u_mem.mem[8'h80], regs[1]);
      chk(u_mem.mem[8'h81], regs[5]);
      chk(u_mem.mem[8'h82], regs[7]);
      chk(u_mem.mem[8'h83], 32'h4c);
      chk(addrs[3], 32'h20d);
      chk(regs[9], 32'h211);
      regs[10] = 32'h300;
      u_mem.mem[8'hbe] = 32'h777;
      u_mem.mem[8'hbf] = 32'h400;
      run(blk(5'h15, 4'ha, 16'h8001), 32'h0, 32'h00010302);
      chk(regs[0], 32'h777);
      chk(regs[15], 32'h400);
      chk(32'(psr_n), 32'h1);
      chk(regs[10], 32'h300);
      regs[11] = 32'h310;
      u_mem.mem[8'hc4] = 32'h999;
      run(blk(5'h05, 4'hb, 16'h2000), 32'h0, 32'h00010101);
      chk(uregs[13], 32'h999);
      chk(regs[13], 32'hc00d);
      regs[12] = 32'h320;
      u_mem.mem[8'hc9] = 32'haaa;
      u_mem.mem[8'hca] = 32'hbbb;
      run(blk(5'h1b, 4'hc, 16'h1008), 32'h0, 32'h00010201);
      chk(regs[3], 32'haaa);
      chk(regs[12], 32'hbbb);
      regs[8] = 32'h340;
      run(blk(5'h0c, 4'h8, 16'hc000), 32'h0, 32'h00000102);
      chk(u_mem.mem[8'hd0], 32'hd00e);
      chk(u_mem.mem[8'hd1], 32'hc);
      chk({31'h0, ub}, 32'h1);
      // An unsupported class is taken and dropped, leaving only the sticky flag.
      @(posedge clock);
      issue_valid <= 1'b1;
      issue_instr <= 32'he0800000;
      @(posedge clock);
      issue_valid <= 1'b0;
      apb(1'b0, `LSMU_STATUS_OFF, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, `LSMU_STATUS_OFF, 32'h2);
      apb(1'b0, `LSMU_STATUS_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `LSMU_COUNT_OFF, 32'h0);
      chk(rd, 32'(n_ins));
      end_of_test();
   end
endmodule
